/* core_model.sv */
// Purpose: Processor core side that watches the normal request line
// Assumes: Request is a level, held until the cause goes away
// Notes:   Counts each new request; a level held high counts once
module core_model (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Request from the block and what the core has seen
  input  wire logic       normal_req_in,
  output logic      [7:0] taken_count_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic req_q;

  // Edge detect, so a long request is not taken twice
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      req_q           <= 1'b0;
      taken_count_out <= 8'h00;
    end else begin
      req_q <= normal_req_in;
      if (normal_req_in && !req_q) begin
        taken_count_out <= taken_count_out + 8'h01;
      end
    end
  end
endmodule // core_model

/* level_pend_ctrl.sv */
// Purpose: Per-level pending view and normal enable mask with AXI4-Lite access
// Assumes: Sources are pre-grouped by level: one request line per level
// Notes:   Normal request is a level toward the core, with event interrupts
//
// Behaviour
// - Pending bit per level mirrors asserted requests
// - Pending view read-only, writes answer OKAY
// - Reset clears all pending bits
// - Enable mask admits levels as normal
// - Enabling an asserted level raises request
// - Reset clears the normal enable mask
// - Enable reads back; pending view unwritable
// - Normal pending bit per enabled asserted level
// - Read-only flag shows normal request state
`include "level_pend_defines.svh"

module level_pend_ctrl #(
  parameter int LEVELS = 32
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // Interrupt sources, one asynchronous line per priority level
  input  wire logic [LEVELS-1:0] level_req_in,
  // Toward the processor core
  output logic                   normal_req_out,
  output logic                   irq_out,
  // AXI4-Lite write address
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [31:0]       s_axi_awaddr_in,
  // AXI4-Lite write data
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  // AXI4-Lite write response
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  output logic [1:0]             s_axi_bresp_out,
  // AXI4-Lite read address
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  input  wire logic [31:0]       s_axi_araddr_in,
  // AXI4-Lite read data
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out
);

  typedef struct packed {
    level_pend_pkg::wr_state_type wr_state;
    logic                         aw_held;
    logic [31:0]                  aw_addr;
    logic                         w_held;
    logic [31:0]                  w_data;
    logic [3:0]                   w_strb;
    logic [1:0]                   bresp;
    level_pend_pkg::rd_state_type rd_state;
    logic [31:0]                  rdata;
    logic [1:0]                   rresp;
    logic [LEVELS-1:0]            pending;
    logic [LEVELS-1:0]            enable;
    logic [LEVELS-1:0]            normal_pend;
    logic                         normal_req;
    logic [`LVL_EVT_W-1:0]        evt_status;
    logic [`LVL_EVT_W-1:0]        evt_mask;
  } ctrl_state_type;

  ctrl_state_type    state_q;
  ctrl_state_type    state_d;
  logic [LEVELS-1:0] req_clean;

  ////////////////////////////////////////////////////////////////////////////
  // Request lines come from outside this clock, so each is synchronised
  level_req_sync #(
    .WIDTH (LEVELS)
  ) u_req_sync (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .raw_in    (level_req_in),
    .clean_out (req_clean)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Merge a write under its byte strobes
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // True when an address hits a mapped word
  function automatic logic addr_mapped(input logic [31:0] a);
    logic [31:0] w;
    w = {a[31:2], 2'b00};
    return (w == `LVL_OFF_PENDING_VIEW) || (w == `LVL_OFF_NORMAL_ENABLE) ||
           (w == `LVL_OFF_NORMAL_PEND) || (w == `LVL_OFF_STATUS) ||
           (w == `LVL_OFF_EVT_STATUS) || (w == `LVL_OFF_EVT_MASK);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [31:0]           waddr;
    logic [31:0]           raddr;
    logic [31:0]           wword;
    logic [31:0]           rword;
    logic [LEVELS-1:0]     enable_next;
    logic [LEVELS-1:0]     npend_next;
    logic                  nreq_next;
    logic [`LVL_EVT_W-1:0] evt_set;
    logic [`LVL_EVT_W-1:0] evt_clr;
    logic                  do_write;
    waddr       = 32'h0000_0000;
    raddr       = 32'h0000_0000;
    wword       = 32'h0000_0000;
    rword       = 32'h0000_0000;
    enable_next = state_q.enable;
    evt_clr     = '0;
    do_write    = 1'b0;
    npend_next  = '0;
    nreq_next   = 1'b0;
    evt_set     = '0;
    state_d     = state_q;

    // Write side: address and data are caught in either order
    if (s_axi_awvalid_in && !state_q.aw_held && state_q.wr_state == level_pend_pkg::WR_IDLE) begin
      state_d.aw_held = 1'b1;
      state_d.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !state_q.w_held && state_q.wr_state == level_pend_pkg::WR_IDLE) begin
      state_d.w_held = 1'b1;
      state_d.w_data = s_axi_wdata_in;
      state_d.w_strb = s_axi_wstrb_in;
    end
    case (state_q.wr_state)
      level_pend_pkg::WR_IDLE: begin
        if (state_q.aw_held && state_q.w_held) begin
          do_write         = 1'b1;
          waddr            = {state_q.aw_addr[31:2], 2'b00};
          state_d.aw_held  = 1'b0;
          state_d.w_held   = 1'b0;
          state_d.wr_state = level_pend_pkg::WR_RESP;
          state_d.bresp    = addr_mapped(waddr) ? `LVL_RESP_OKAY : `LVL_RESP_DECERR;
        end
      end
      level_pend_pkg::WR_RESP: begin
        if (s_axi_bready_in) begin
          state_d.wr_state = level_pend_pkg::WR_IDLE;
        end
      end
      default: state_d.wr_state = level_pend_pkg::WR_IDLE;
    endcase

    // Only the mask and event registers hold writable bits
    if (do_write) begin
      if (waddr == `LVL_OFF_NORMAL_ENABLE) begin
        // Size cast avoids a zero-width fill when all 32 levels are present
        wword       = merge_strb(32'(state_q.enable), state_q.w_data, state_q.w_strb);
        enable_next = wword[LEVELS-1:0];
      end else if (waddr == `LVL_OFF_EVT_STATUS) begin
        wword   = merge_strb(32'h0000_0000, state_q.w_data, state_q.w_strb);
        evt_clr = wword[`LVL_EVT_W-1:0];
      end else if (waddr == `LVL_OFF_EVT_MASK) begin
        wword            = merge_strb({{(32-`LVL_EVT_W){1'b0}}, state_q.evt_mask},
                                      state_q.w_data, state_q.w_strb);
        state_d.evt_mask = wword[`LVL_EVT_W-1:0];
      end
      // Writes to the pending views fall through unchanged
    end
    state_d.enable = enable_next;

    // Pending view tracks the synchronised lines, never software
    state_d.pending = req_clean;
    // Normal pending uses the new mask, so enabling a live level acts at once
    npend_next          = req_clean & enable_next;
    state_d.normal_pend = npend_next;
    nreq_next           = |npend_next;
    state_d.normal_req  = nreq_next;

    // Events on the core request line; a set beats a same-cycle clear
    evt_set[`LVL_EVT_REQ_RISE_BIT] = nreq_next && !state_q.normal_req;
    evt_set[`LVL_EVT_REQ_FALL_BIT] = !nreq_next && state_q.normal_req;
    state_d.evt_status = (state_q.evt_status & ~evt_clr) | evt_set;

    // Read side: one read at a time, data from a register
    case (state_q.rd_state)
      level_pend_pkg::RD_IDLE: begin
        if (s_axi_arvalid_in) begin
          raddr = {s_axi_araddr_in[31:2], 2'b00};
          if (raddr == `LVL_OFF_PENDING_VIEW) begin
            rword = 32'(state_q.pending);
          end else if (raddr == `LVL_OFF_NORMAL_ENABLE) begin
            rword = 32'(state_q.enable);
          end else if (raddr == `LVL_OFF_NORMAL_PEND) begin
            rword = 32'(state_q.normal_pend);
          end else if (raddr == `LVL_OFF_STATUS) begin
            rword[`LVL_STATUS_REQ_BIT] = state_q.normal_req;
          end else if (raddr == `LVL_OFF_EVT_STATUS) begin
            rword[`LVL_EVT_W-1:0] = state_q.evt_status;
          end else if (raddr == `LVL_OFF_EVT_MASK) begin
            rword[`LVL_EVT_W-1:0] = state_q.evt_mask;
          end
          state_d.rdata    = rword;
          state_d.rresp    = addr_mapped(raddr) ? `LVL_RESP_OKAY : `LVL_RESP_DECERR;
          state_d.rd_state = level_pend_pkg::RD_DATA;
        end
      end
      level_pend_pkg::RD_DATA: begin
        if (s_axi_rready_in) begin
          state_d.rd_state = level_pend_pkg::RD_IDLE;
        end
      end
      default: state_d.rd_state = level_pend_pkg::RD_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; reset clears pending, mask and request flag
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshakes; ready only while idle so one write is held at a time
  assign s_axi_awready_out = !state_q.aw_held && state_q.wr_state == level_pend_pkg::WR_IDLE;
  assign s_axi_wready_out  = !state_q.w_held && state_q.wr_state == level_pend_pkg::WR_IDLE;
  assign s_axi_bvalid_out  = state_q.wr_state == level_pend_pkg::WR_RESP;
  assign s_axi_bresp_out   = state_q.bresp;
  assign s_axi_arready_out = state_q.rd_state == level_pend_pkg::RD_IDLE;
  assign s_axi_rvalid_out  = state_q.rd_state == level_pend_pkg::RD_DATA;
  assign s_axi_rdata_out   = state_q.rdata;
  assign s_axi_rresp_out   = state_q.rresp;

  // Core request straight from a flip-flop; irq_out is the masked OR of event flip-flops
  assign normal_req_out = state_q.normal_req;
  assign irq_out        = |(state_q.evt_status & state_q.evt_mask);

endmodule // level_pend_ctrl

/* level_pend_ctrl_asserts.sv */
// Purpose: Port checks for the level pending block
// Assumes: One clock, asynchronous reset
// Notes:   Bound to every instance of level_pend_ctrl
`include "level_pend_defines.svh"

module level_pend_ctrl_asserts (
  // Clock, reset, requests
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic [31:0] level_req_in,
  input wire logic        normal_req_out,
  input wire logic        irq_out,
  // Register bus
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic [31:0] s_axi_awaddr_in,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Handshakes seen at the port
  wire wr_hs = s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  wire ar_hs = s_axi_arvalid_in && s_axi_arready_out;

  ////////////////////////////////////////////////////////////
  reset_quiet_a: assert property ($past(rst_in) |-> !normal_req_out && !irq_out)
    else $error("request active after reset");
  // Sync plus pending register is five edges, six idle cycles are just enough, with no margin
  idle_quiet_a: assert property ((level_req_in == 32'h0000_0000) [*6] |-> !normal_req_out)
    else $error("normal request with no source");
  wr_answer_a: assert property (wr_hs |-> ##[1:2] s_axi_bvalid_out)
    else $error("write not answered");
  ro_write_a: assert property (wr_hs && s_axi_awaddr_in == `LVL_OFF_PENDING_VIEW
    |-> ##[1:2] s_axi_bvalid_out && s_axi_bresp_out == `LVL_RESP_OKAY)
    else $error("pending view write not OKAY");
  rd_answer_a: assert property (ar_hs |=> s_axi_rvalid_out)
    else $error("read not answered");
  b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in
    |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped");
  ar_block_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read taken while answer pending");
  // Main scenarios reached
  req_rise_c: cover property ($rose(normal_req_out));
  irq_rise_c: cover property ($rose(irq_out));
  decerr_c: cover property (s_axi_bvalid_out && s_axi_bresp_out == `LVL_RESP_DECERR);
endmodule // level_pend_ctrl_asserts

bind level_pend_ctrl level_pend_ctrl_asserts chk_i (.*);

/* level_pend_defines.svh */
// Purpose: Register offsets, reset values and sizes for the level pending block
// Assumes: Included by bare name, definitions only
// Notes:   Offsets are full byte addresses, the low two bits are ignored
`ifndef LEVEL_PEND_DEFINES_SVH
`define LEVEL_PEND_DEFINES_SVH

`define LVL_ADDR_W            32
`define LVL_OFF_PENDING_VIEW  32'h00c5_000c
`define LVL_OFF_NORMAL_ENABLE 32'h00c5_0010
`define LVL_OFF_NORMAL_PEND   32'h00c5_0020
`define LVL_OFF_STATUS        32'h00c5_0024
`define LVL_OFF_EVT_STATUS    32'h00c5_0028
`define LVL_OFF_EVT_MASK      32'h00c5_002c
`define LVL_RST_WORD          32'h0000_0000
`define LVL_STATUS_REQ_BIT    0
`define LVL_EVT_REQ_RISE_BIT  0
`define LVL_EVT_REQ_FALL_BIT  1
`define LVL_EVT_W             2
`define LVL_SYNC_STAGES       3
`define LVL_RESP_OKAY         2'b00
`define LVL_RESP_DECERR       2'b11

`endif

/* level_pend_pkg.sv */
// Purpose: Types shared by the level pending block
// Assumes: Nothing beyond the defines header
// Notes:   Bus slave states only
package level_pend_pkg;
  typedef enum logic [1:0] {
    WR_IDLE,
    WR_RESP
  } wr_state_type;
  typedef enum logic [1:0] {
    RD_IDLE,
    RD_DATA
  } rd_state_type;
endpackage

/* level_req_sync.sv */
// Purpose: Three stage synchroniser with agreement filter, one per request line
// Assumes: Request lines are asynchronous to clk_in
// Notes:   Output moves only when stages two and three agree
`include "level_pend_defines.svh"

module level_req_sync #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Raw and filtered requests
  input  wire logic [WIDTH-1:0] raw_in,
  output logic      [WIDTH-1:0] clean_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] clean;
  } sync_state_type;

  sync_state_type state_q;
  sync_state_type state_d;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: the first stage is read only by the second
  always_comb begin
    state_d    = state_q;
    state_d.s1 = raw_in;
    state_d.s2 = state_q.s1;
    state_d.s3 = state_q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (state_q.s2[i] == state_q.s3[i]) begin
        state_d.clean[i] = state_q.s3[i];
      end
    end
  end

  // Registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign clean_out = state_q.clean;

endmodule // level_req_sync

/* tb_level_pend_ctrl.sv */
// Purpose: Self-checking bench for the level pending block
// Assumes: AXI4-Lite master tasks, core model on the request line
// Notes:   Sync delay of five edges is waited out with six
`include "level_pend_defines.svh"

module tb_level_pend_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] a_pend = `LVL_OFF_PENDING_VIEW;
  localparam logic [31:0] a_en = `LVL_OFF_NORMAL_ENABLE;
  localparam logic [31:0] a_npend = `LVL_OFF_NORMAL_PEND;
  localparam logic [31:0] a_stat = `LVL_OFF_STATUS;
  localparam logic [31:0] a_evs = `LVL_OFF_EVT_STATUS;
  localparam logic [31:0] a_evm = `LVL_OFF_EVT_MASK;
  localparam logic [31:0] a_bad = 32'h00c5_0030;
  localparam logic [1:0]  ok = `LVL_RESP_OKAY;
  localparam logic [1:0]  de = `LVL_RESP_DECERR;
  logic clk_in = 1'b0, rst_in = 1'b1;
  logic [31:0] level_req_in = 32'h0000_0000, s_axi_awaddr_in = 32'h0000_0000;
  logic [31:0] s_axi_wdata_in = 32'h0000_0000, s_axi_araddr_in = 32'h0000_0000;
  logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
  logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
  logic [3:0]  s_axi_wstrb_in = 4'hf;
  logic normal_req_out, irq_out, s_axi_awready_out, s_axi_wready_out;
  logic s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
  logic [31:0] s_axi_rdata_out;
  logic [7:0]  taken_count;
  int err_count = 0, checked = 0, cyc = 0;

  level_pend_ctrl uut (.*);
  core_model core (
    .clk_in          (clk_in),
    .rst_in          (rst_in),
    .normal_req_in   (normal_req_out),
    .taken_count_out (taken_count)
  );

  ////////////////////////////////////////////////////////////
  // 10 MHz clock; hang guard at 3000 cycles, well above the expected run of about a hundred cycles
  initial forever #50 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("Checks %0d, errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Address and data offered together; each released once taken
  task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do begin
      @(posedge clk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end while (!s_axi_bvalid_out);
    chk({30'h0000_0000, s_axi_bresp_out}, {30'h0000_0000, er});
    s_axi_bready_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rd(input logic [31:0] a, e, input logic [1:0] er);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do begin
      @(posedge clk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end while (!s_axi_rvalid_out);
    chk(s_axi_rdata_out, e);
    chk({30'h0000_0000, s_axi_rresp_out}, {30'h0000_0000, er});
    s_axi_rready_in <= 1'b0;
    @(posedge clk_in);
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rd(a_pend, 32'h0000_0000, ok);
    rd(a_en, 32'h0000_0000, ok);
    wr(a_pend, 32'hffff_ffff, ok);
    rd(a_pend, 32'h0000_0000, ok);
    wr(a_en, 32'ha5a5_5a5a, ok);
    rd(a_en, 32'ha5a5_5a5a, ok);
    level_req_in <= 32'h0000_0081;
    repeat (6) @(posedge clk_in);
    rd(a_pend, 32'h0000_0081, ok);
    rd(a_npend, 32'h0000_0000, ok);
    chk({31'h0000_0000, normal_req_out}, 32'h0000_0000);
    wr(a_en, 32'h0000_0080, ok);
    chk({31'h0000_0000, normal_req_out}, 32'h0000_0001);
    rd(a_stat, 32'h0000_0001, ok);
    rd(a_npend, 32'h0000_0080, ok);
    level_req_in <= 32'h0000_0000;
    repeat (6) @(posedge clk_in);
    chk({31'h0000_0000, normal_req_out}, 32'h0000_0000);
    rd(a_pend, 32'h0000_0000, ok);
    rd(a_stat, 32'h0000_0000, ok);
    // Both events are stored but masked; unmask and clear one at a time
    rd(a_evs, 32'h0000_0003, ok);
    chk({31'h0000_0000, irq_out}, 32'h0000_0000);
    wr(a_evm, 32'h0000_0001, ok);
    chk({31'h0000_0000, irq_out}, 32'h0000_0001);
    wr(a_evs, 32'h0000_0001, ok);
    rd(a_evs, 32'h0000_0002, ok);
    chk({31'h0000_0000, irq_out}, 32'h0000_0000);
    wr(a_evm, 32'h0000_0003, ok);
    chk({31'h0000_0000, irq_out}, 32'h0000_0001);
    wr(a_evs, 32'h0000_0002, ok);
    chk({31'h0000_0000, irq_out}, 32'h0000_0000);
    wr(a_bad, 32'h1234_5678, de);
    rd(a_bad, 32'h0000_0000, de);
    chk({24'h00_0000, taken_count}, 32'h0000_0001);
    // Live level with its enable set, then a mid-run reset must clear it all
    level_req_in <= 32'h0000_0081;
    wr(a_en, 32'h0000_0081, ok);
    repeat (6) @(posedge clk_in);
    rd(a_npend, 32'h0000_0081, ok);
    chk({31'h0000_0000, irq_out}, 32'h0000_0001);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rd(a_pend, 32'h0000_0000, ok);
    rd(a_en, 32'h0000_0000, ok);
    chk({31'h0000_0000, normal_req_out}, 32'h0000_0000);
    chk({31'h0000_0000, irq_out}, 32'h0000_0000);
    rd(a_stat, 32'h0000_0000, ok);
    finish_test();
  end
endmodule // tb_level_pend_ctrl
